//--- hw/io_parity_card.sv
// I/O bus parity generator: parity lines and access stall for the coupler.
// Assumes bus pins are asynchronous to mclk and jumpers are static.
// Summary of operation
// - Parity computed from address and data on every covered access.
// - Jumpers choose classical or feedback parity scheme.
// - Feedback scheme computes parity for both reads and writes.
// - Covered feedback write stalls the access until parity has settled.
// - Stall re-asserted on trailing edge of the strobe in the feedback scheme.
// - Read drops the stall quickly on the leading strobe edge.
// - Parity runs continuously; valid a settle time after transfer-complete.
// - I/O-only option covers addresses in the I/O range only.
// - Except-memory-reads option skips reads below the I/O range.
// - All-addresses option covers every access.
// - One parity bit per byte over eight data and twenty address bits.
// - Upper byte address ends in zero, lower byte address is odd on word references.
// - Parity makes total ones of address, data and parity even.
// - Word references ignore address bit zero, use implicit byte addresses.
// - Byte references use bit zero and the low byte position.
// - Fast-tree jumper shortens the feedback write stall, 140 vs 200 ns.
// - Classical scheme asserts the stall line only from reset until the first strobe.
// - Parity lines driven only while an I/O address is detected.
// - Stall held as briefly as possible for off-bus references.
// - Strobe, stall and transfer-complete are active low.
module io_parity_card (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire iopar_pkg::iopar_cfg_t cfgPins,
  input  wire iopar_pkg::iopar_bus_t busPins,
  output iopar_pkg::iopar_out_t     busOut,
  output logic                      parityValid
);
  import iopar_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WSTALL,
    ST_ACTIVE
  } iopar_state_t;

  typedef struct packed {
    logic [1:0]   rstSync;
    logic         cfgTaken;
    iopar_cfg_t   cfg;
    iopar_bus_t   busMeta;
    iopar_bus_t   bus;
    logic         strobePrev;
    logic         donePrev;
    iopar_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] settle;
    logic         stall;
    logic         covered;
    logic         drive;
    logic         valid;
  } iopar_st_t;

  iopar_st_t   st;
  iopar_st_t   next_st;
  logic        rstSync_n;
  logic [19:0] addrUpper;
  logic [19:0] addrLower;
  logic [7:0]  dataUpper;
  logic [7:0]  dataLower;
  logic        parUpper;
  logic        parLower;
  logic        strobeAct;
  logic        doneAct;
  logic        strobeRise;
  logic        strobeFall;
  logic        doneRise;
  logic        inIo;
  logic        coveredNow;
  logic [CNT_W-1:0] stallCyc;

  // Reset release through two flops; separate from the struct so the
  // whole struct can use the synchronised copy
  logic [1:0] rstPipe;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  // Controls are active low on the pins
  assign strobeAct  = ~st.bus.strobe_n;
  assign doneAct    = ~st.bus.done_n;
  assign strobeRise = strobeAct & ~st.strobePrev;
  assign strobeFall = ~strobeAct & st.strobePrev;
  assign doneRise   = doneAct & ~st.donePrev;

  // Address range decode for the coverage options
  assign inIo = (st.bus.addr >= IO_LOW) && (st.bus.addr < IO_HIGH);
  always_comb begin
    unique case (st.cfg.range)
      IOPAR_RANGE_IO_ONLY:  coveredNow = inIo;
      IOPAR_RANGE_NO_MEMRD: coveredNow = (st.bus.addr >= IO_LOW)
                                         | st.bus.write;
      IOPAR_RANGE_ALL:      coveredNow = 1'b1;
      default:              coveredNow = inIo;
    endcase
  end

  // Stall length follows the tree jumper
  assign stallCyc = st.cfg.fastTrees ? CNT_W'(STALL_FAST_CYC)
                                     : CNT_W'(STALL_STD_CYC);

  // Per-byte operands; bit zero implicit on words, real on bytes
  always_comb begin
    addrUpper = {st.bus.addr[19:1], 1'b0};
    addrLower = {st.bus.addr[19:1], 1'b1};
    dataUpper = st.bus.data[15:8];
    dataLower = st.bus.data[7:0];
    if (st.bus.byteRef) begin
      addrLower = st.bus.addr;
    end
  end

  // Two parity trees, one per byte, running continuously
  iopar_tree uTreeUpper (
    .mclk      (mclk),
    .rstSync_n (rstSync_n),
    .addr      (addrUpper),
    .data      (dataUpper),
    .parity    (parUpper)
  );
  iopar_tree uTreeLower (
    .mclk      (mclk),
    .rstSync_n (rstSync_n),
    .addr      (addrLower),
    .data      (dataLower),
    .parity    (parLower)
  );

  // Next-state logic for the whole block
  always_comb begin
    next_st            = st;
    next_st.busMeta    = busPins;
    next_st.bus        = st.busMeta;
    next_st.strobePrev = strobeAct;
    next_st.donePrev   = doneAct;
    // Jumpers caught once after reset release
    if (!st.cfgTaken) begin
      next_st.cfg      = cfgPins;
      next_st.cfgTaken = 1'b1;
    end
    unique case (st.state)
      ST_IDLE: begin
        if (strobeRise) begin
          next_st.covered = coveredNow;
          if (!st.cfg.feedback) begin
            next_st.stall = 1'b0;
            next_st.state = ST_ACTIVE;
          end else if (st.bus.write && coveredNow) begin
            next_st.cnt   = stallCyc;
            next_st.state = ST_WSTALL;
          end else begin
            // Reads and off-bus writes release at once
            next_st.stall = 1'b0;
            next_st.state = ST_ACTIVE;
          end
        end
      end
      ST_WSTALL: begin
        if (st.cnt <= CNT_W'(1)) begin
          next_st.stall = 1'b0;
          next_st.state = ST_ACTIVE;
        end else begin
          next_st.cnt = st.cnt - CNT_W'(1);
        end
        if (strobeFall) begin
          next_st.stall = st.cfg.feedback;
          next_st.state = ST_IDLE;
        end
      end
      ST_ACTIVE: begin
        if (strobeFall) begin
          // Ready the stall for the next cycle
          next_st.stall   = st.cfg.feedback;
          next_st.covered = 1'b0;
          next_st.state   = ST_IDLE;
        end
      end
    endcase
    // Parity valid a fixed settle time after transfer-complete
    if (doneRise) begin
      next_st.settle = CNT_W'(SETTLE_CYC);
      next_st.valid  = 1'b0;
    end else if (st.settle != CNT_W'(0)) begin
      next_st.settle = st.settle - CNT_W'(1);
      next_st.valid  = (st.settle == CNT_W'(1));
    end
    if (!strobeAct) begin
      next_st.valid = 1'b0;
    end
    // Lines driven only on a covered I/O address
    next_st.drive = inIo & coveredNow & strobeAct;
  end

  // State register; reset leaves the stall asserted
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st       <= '0;
      st.stall <= STALL_RESET;
      st.state <= ST_IDLE;
      st.bus.strobe_n     <= 1'b1;
      st.bus.done_n       <= 1'b1;
      st.busMeta.strobe_n <= 1'b1;
      st.busMeta.done_n   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Pin outputs
  assign busOut.parUpper = st.drive & parUpper;
  assign busOut.parLower = st.drive & parLower;
  assign busOut.parOe    = st.drive;
  assign busOut.stall_n  = ~st.stall;
  assign parityValid     = st.valid;

  // Assertions
  a_classic_nostall: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && !st.cfg.feedback && st.state != ST_IDLE |-> !st.stall)
    else $error("Stall asserted under classical scheme");
  a_read_release: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && strobeRise && !st.bus.write && st.state == ST_IDLE
    |=> !st.stall)
    else $error("Read did not release stall");
  a_refall_stall: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.cfg.feedback && strobeFall && st.state != ST_IDLE
    |=> st.stall)
    else $error("Stall not re-asserted on strobe fall");
  a_write_hold: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.state == ST_IDLE ##1 st.state == ST_WSTALL |-> st.stall[*2])
    else $error("Write stall too short");
  a_write_bound: assert property (@(posedge mclk) disable iff (!rstSync_n)
    $rose(st.state == ST_WSTALL) |-> ##[1:25] st.state != ST_WSTALL)
    else $error("Write stall too long");
  a_drive_io: assert property (@(posedge mclk) disable iff (!rstSync_n)
    busOut.parOe |-> $past(inIo))
    else $error("Parity driven off I/O range");
  // Trees still hold their reset value one edge after release
  a_even_lower: assert property (@(posedge mclk) disable iff (!rstSync_n)
    $past(rstSync_n) |->
    ^{$past(addrLower), $past(dataLower), parLower} == 1'b0)
    else $error("Lower parity not even");
  a_cfg_static: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken |=> $stable(st.cfg))
    else $error("Configuration changed");
  a_valid_settle: assert property (@(posedge mclk) disable iff (!rstSync_n)
    parityValid && !$past(parityValid) |-> $past(st.settle) == CNT_W'(1))
    else $error("Parity valid without settle");

  // Upper byte tree, same even sense as the lower one
  a_even_upper: assert property (@(posedge mclk) disable iff (!rstSync_n)
    $past(rstSync_n) |->
    ^{$past(addrUpper), $past(dataUpper), parUpper} == 1'b0)
    else $error("Upper parity not even");

  // Undriven lines must sit at zero
  a_lines_quiet: assert property (@(posedge mclk) disable iff (!rstSync_n)
    !busOut.parOe |-> !busOut.parUpper && !busOut.parLower)
    else $error("Parity line set while not driven");

  // Upper byte address always even
  a_upper_zero: assert property (@(posedge mclk) disable iff (!rstSync_n)
    addrUpper[0] == 1'b0)
    else $error("Upper byte address odd");

  // Word references force the lower byte address odd
  a_word_odd: assert property (@(posedge mclk) disable iff (!rstSync_n)
    !st.bus.byteRef |-> addrLower[0])
    else $error("Word lower address not odd");

  // Byte references keep the real address
  a_byte_addr: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.bus.byteRef |-> addrLower == st.bus.addr)
    else $error("Byte address not taken from bus");

  // I/O-only option follows the range decode
  a_range_io: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.state == ST_IDLE && strobeRise &&
    st.cfg.range == IOPAR_RANGE_IO_ONLY |=> st.covered == $past(inIo))
    else $error("I/O-only coverage wrong");

  // All-addresses option covers everything
  a_range_all: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.state == ST_IDLE && strobeRise &&
    st.cfg.range == IOPAR_RANGE_ALL |=> st.covered)
    else $error("All-address access not covered");

  // Memory reads skipped under the except-memory-reads option
  a_range_memrd: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.state == ST_IDLE && strobeRise &&
    st.cfg.range == IOPAR_RANGE_NO_MEMRD && !st.bus.write &&
    st.bus.addr < IO_LOW |=> !st.covered)
    else $error("Memory read covered");

  // Write stall loads the length picked by the tree jumper
  a_stall_load: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.state == ST_IDLE && strobeRise && st.cfg.feedback &&
    st.bus.write && coveredNow
    |=> st.state == ST_WSTALL && st.cnt == $past(stallCyc))
    else $error("Write stall length wrong");

  // Valid never survives a released strobe
  a_valid_strobe: assert property (@(posedge mclk) disable iff (!rstSync_n)
    parityValid |-> $past(strobeAct))
    else $error("Parity valid outside strobe");

  // Stall latch comes out of reset asserted
  a_reset_stall: assert property (@(posedge mclk) disable iff (!rstSync_n)
    !$past(rstSync_n) |-> st.stall)
    else $error("Stall not set after reset");

  // Settle count starts at transfer-complete
  a_done_load: assert property (@(posedge mclk) disable iff (!rstSync_n)
    doneRise |=> st.settle == CNT_W'(SETTLE_CYC))
    else $error("Settle count not loaded");

  // Coverage ends with an access that reaches the active state
  a_covered_drop: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.state == ST_ACTIVE && strobeFall |=> !st.covered)
    else $error("Coverage kept after access");

  // Lines only driven inside a strobe
  a_oe_strobe: assert property (@(posedge mclk) disable iff (!rstSync_n)
    busOut.parOe |-> $past(strobeAct))
    else $error("Parity driven without strobe");

  // Feedback reads go straight to the active state
  a_fb_read: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.cfg.feedback && st.state == ST_IDLE &&
    strobeRise && !st.bus.write |=> st.state == ST_ACTIVE)
    else $error("Feedback read stalled");

  // Feedback idle always has the stall armed
  a_idle_stall: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && st.cfg.feedback && st.state == ST_IDLE |-> st.stall)
    else $error("Stall not armed in idle");

  // Stall held for the whole write wait
  a_wstall_held: assert property (@(posedge mclk) disable iff (!rstSync_n)
    st.state == ST_WSTALL |-> st.stall)
    else $error("Stall dropped during write wait");

  c_write_stall: cover property (@(posedge mclk) disable iff (!rstSync_n)
    st.state == ST_WSTALL ##[1:25] st.state == ST_ACTIVE);
  c_read_fast: cover property (@(posedge mclk) disable iff (!rstSync_n)
    strobeRise && !st.bus.write ##1 !st.stall);
  c_valid: cover property (@(posedge mclk) disable iff (!rstSync_n)
    parityValid && busOut.parOe);
  // Byte references and classical accesses
  c_byte_ref: cover property (@(posedge mclk) disable iff (!rstSync_n)
    strobeRise && st.bus.byteRef);
  c_classic: cover property (@(posedge mclk) disable iff (!rstSync_n)
    st.cfgTaken && !st.cfg.feedback && strobeRise);
endmodule

//--- hw/iopar_pkg.sv
// Package for the I/O bus parity generator: constants and carrier types.
// Assumes a single 100 MHz clock domain; all bus pins arrive asynchronously.
package iopar_pkg;

  localparam int ADDR_W   = 20;
  localparam int DATA_W   = 16;
  localparam int CLK_NS   = 10;
  // Feedback write stall times in ns, fast and standard trees
  localparam int STALL_FAST_NS = 140;
  localparam int STALL_STD_NS  = 200;
  // Longest times round down to whole cycles, at least one
  localparam int STALL_FAST_CYC =
    (STALL_FAST_NS / CLK_NS) < 1 ? 1 : STALL_FAST_NS / CLK_NS;
  localparam int STALL_STD_CYC  =
    (STALL_STD_NS / CLK_NS) < 1 ? 1 : STALL_STD_NS / CLK_NS;
  localparam int CNT_W = 5;
  // Parity settling after transfer-complete, in cycles
  localparam int SETTLE_CYC = 3;
  // Address ranges: I/O space FC000..FFC00, memory space below FC000
  localparam logic [19:0] IO_LOW   = 20'hFC000;
  localparam logic [19:0] IO_HIGH  = 20'hFFC00;
  // Reset state of the stall latch: asserted
  localparam logic STALL_RESET = 1'b1;

  typedef enum logic [1:0] {
    IOPAR_RANGE_IO_ONLY,
    IOPAR_RANGE_NO_MEMRD,
    IOPAR_RANGE_ALL
  } iopar_range_t;

  // Static jumper configuration
  typedef struct packed {
    logic         feedback;
    iopar_range_t range;
    logic         fastTrees;
  } iopar_cfg_t;

  // Bus access as seen on the pins (active-low controls)
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        write;
    logic        byteRef;
    logic        strobe_n;
    logic        done_n;
  } iopar_bus_t;

  typedef struct packed {
    logic parUpper;
    logic parLower;
    logic parOe;
    logic stall_n;
  } iopar_out_t;

endpackage

//--- hw/iopar_tree.sv
// Parity tree for one byte: even parity over 8 data and 20 address bits.
// Inputs come from registered pin copies; output is registered.
module iopar_tree (
  input  wire logic        mclk,
  input  wire logic        rstSync_n,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  data,
  output logic             parity
);
  import iopar_pkg::*;

  // Even parity: the bit makes the total count of ones even
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      parity <= 1'b0;
    end else begin
      parity <= ^{addr, data};
    end
  end
endmodule

//--- test/iopar_coupler.sv
// Bus coupler model: runs one access on the I/O bus and times the card.
// Assumes mclk from the bench; pins change only just after rising edges.
module iopar_coupler (
  input  wire logic                  mclk,
  output iopar_pkg::iopar_bus_t      busPins,
  input  wire iopar_pkg::iopar_out_t busOut,
  input  wire logic                  parityValid
);
  timeunit 1ns;
  timeprecision 1ps;
  import iopar_pkg::*;

  // Idle bus, controls inactive high
  initial begin
    busPins = '{addr: 20'h00000, data: 16'h0000, write: 1'b0,
                byteRef: 1'b0, strobe_n: 1'b1, done_n: 1'b1};
  end

  // One access: strobe, wait for stall release, done, settle, release
  task automatic access(input logic [19:0] a, input logic [15:0] d,
                        input logic wr, input logic by, input bit cov,
                        output int stallCyc, output int validCyc,
                        output iopar_out_t seen, output int relCyc);
    stallCyc = 0;
    validCyc = 0;
    relCyc = 0;
    @(posedge mclk);
    busPins <= '{addr: a, data: d, write: wr, byteRef: by,
                 strobe_n: 1'b0, done_n: 1'b1};
    do begin
      @(posedge mclk);
      stallCyc++;
    end while (busOut.stall_n !== 1'b1 && stallCyc < 60);
    busPins.done_n <= 1'b0;
    // After done, a covered access is held until parity is valid; otherwise six cycles
    do begin
      @(posedge mclk);
      validCyc++;
    end while ((!cov || parityValid !== 1'b1)
               && validCyc < (cov ? 20 : 6));
    // Coupler only samples the card's lines here; the bench checks them
    seen = busOut;
    // Released lines show the inverse, never a stale value
    busPins <= '{addr: ~a, data: ~d, write: ~wr, byteRef: ~by,
                 strobe_n: 1'b1, done_n: 1'b1};
    repeat (8) begin
      @(posedge mclk);
      if (busOut.stall_n === 1'b1) relCyc++;
    end
  endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the I/O bus parity card with a coupler model.
// Assumes the card's hand-over timing; expectations are computed here.
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iopar_pkg::*;

  logic       mclk;
  logic       nrst;
  iopar_cfg_t cfgPins;
  iopar_bus_t busPins;
  iopar_out_t busOut;
  logic       parityValid;
  int         num_errors;
  int         check_count;
  iopar_out_t seen;

  io_parity_card dut (.mclk(mclk), .nrst(nrst), .cfgPins(cfgPins),
    .busPins(busPins), .busOut(busOut), .parityValid(parityValid));
  iopar_coupler cp (.mclk(mclk), .busPins(busPins), .busOut(busOut),
    .parityValid(parityValid));

  // Reference: which accesses the jumpers cover
  function automatic bit isCovered(int rng, int wr, int a);
    bit io;
    io = (a >= 32'h000FC000) && (a < 32'h000FFC00);
    if (rng == 0) return io;
    if (rng == 1) return (wr != 0) || (a >= 32'h000FC000);
    return 1'b1;
  endfunction

  // Reference: even parity over 20 address and 8 data bits
  function automatic bit parBit(int a, int d);
    bit p;
    p = 1'b0;
    for (int i = 0; i < 20; i++) p ^= a[i];
    for (int i = 0; i < 8; i++) p ^= d[i];
    return p;
  endfunction

  // Closing verdict, shared with the watchdog
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Jumpers only count at reset release, so each setting gets a reset
  task automatic doReset(input bit fb, input int rng, input bit fast);
    @(posedge mclk);
    nrst <= 1'b0;
    cfgPins <= '{feedback: fb, range: iopar_range_t'(rng), fastTrees: fast};
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(busOut.stall_n, 1'b0)
    cfgPins <= iopar_cfg_t'(~cfgPins);
  endtask

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog: about ten times the expected run
  initial begin
    #300us;
    num_errors++;
    final_report();
  end

  // Every scheme, range option and tree speed, with random accesses
  initial begin
    int a, d, wr, by, lim, sc, vc, rc;
    bit cov, lng, fb, fast, io;
    int edgeAddr[4];
    nrst = 1'b0;
    cfgPins = '0;
    num_errors = 0;
    check_count = 0;
    edgeAddr = '{32'hFBFFF, 32'hFC000, 32'hFFBFF, 32'hFFC00};
    void'($urandom(32'h7FE178B1));
    for (int t = 0; t < 12; t++) begin
      fb = t[0];
      fast = t[1];
      doReset(fb, t / 4, fast);
      for (int n = 0; n < 12; n++) begin
        a = (n < 4) ? edgeAddr[n] : (n % 2) ?
            32'hFC000 + $urandom_range(0, 32'h3BFF) :
            $urandom_range(0, 32'hFFFFF);
        d = $urandom_range(0, 32'hFFFF);
        wr = $urandom_range(0, 1);
        by = $urandom_range(0, 1);
        cov = isCovered(t / 4, wr, a);
        io = (a >= 32'h000FC000) && (a < 32'h000FFC00);
        lng = fb && (wr != 0) && cov;
        lim = fast ? STALL_FAST_CYC : STALL_STD_CYC;
        cp.access(a[19:0], d[15:0], wr[0], by[0], cov, sc, vc, seen, rc);
        if (lng) begin
          `CHK(sc >= lim && sc <= lim + 6, 1'b1)
        end else begin
          `CHK(sc <= 8, 1'b1)
        end
        `CHK(seen.parOe, cov && io)
        if (cov) begin
          `CHK(vc >= SETTLE_CYC && vc < 20, 1'b1)
        end
        // Lines only carry parity inside the I/O range
        if (cov && io) begin
          `CHK(seen.parLower, parBit(by ? a : a | 1, d & 32'hFF))
          if (by == 0) `CHK(seen.parUpper, parBit(a & 32'hFFFFE, d >> 8))
        end
        if (fb) `CHK(rc <= 6, 1'b1)
        else `CHK(rc, 8)
      end
      $display("test %0d done: feedback %0d range %0d fast %0d",
               t, fb, t / 4, fast);
    end
    final_report();
  end
endmodule
